// [dv/pee_dev_model.sv]
`timescale 1ns/10ps
// ----
// Behavioural memory device with page latch and unlock.
// ----
module pee_dev_model #(
	parameter LOAD_CYC = 80,
	parameter logic [62:0] UNL = {21'h1555AA, 21'h0AAA55, 21'h1555A0}
) (
	input  logic        clk,
	input  int          progCyc,
	input  logic        chipSel_n,
	input  logic        outGate_n,
	input  logic        writeStrobe_n,
	input  logic [12:0] addressLines,
	input  logic        idAreaSelectPin,
	input  logic [7:0]  dataLinesOut,
	input  logic        dataLinesOe,
	output logic [7:0]  dataLinesIn
);
	logic [7:0] mem [8256], pg [64], last = 0, prevBus = 0;
	logic [63:0] ld = 0;
	logic [12:0] la = 0;
	logic busy = 0, tog = 0, rdq = 0;
	int unl = 0, win = -1, prog = 0, base = 0;
	wire rd = !chipSel_n && !outGate_n && writeStrobe_n;
	initial foreach (mem[k]) mem[k] = 8'hFF;
	function automatic int idx(input logic [12:0] a);
		return (idAreaSelectPin && a[12:6] == 7'h7F) ? 8192 + a[5:0] : a;
	endfunction
	always @(negedge writeStrobe_n)
		if (!chipSel_n && outGate_n) la = addressLines;
	always @(posedge writeStrobe_n)
		if (!chipSel_n && outGate_n && !busy) begin
			if (unl < 3 && {la, dataLinesOut} == UNL[62 - 21 * unl -: 21]) begin
				unl++;
			end else if (unl < 3) begin
				ld = 0;
				win = 0;
			end else begin
				base = idx(la) & ~63;
				pg[la[5:0]] = dataLinesOut;
				ld[la[5:0]] = 1;
				last = dataLinesOut;
				win = 0;
			end
		end
	always @(posedge clk) begin
		if (win >= 0)
			win <= win + 1;
		if (win > LOAD_CYC) begin
			win <= -1;
			busy <= 1;
			prog <= 0;
		end
		if (busy)
			prog <= prog + 1;
		if (busy && prog > progCyc) begin
			for (int i = 0; i < 64; i++) if (ld[i]) mem[base + i] <= pg[i];
			busy <= 0;
			ld <= 0;
			unl <= 0;
		end
		if (rd && !rdq && busy)
			tog <= ~tog;
		rdq <= rd;
		prevBus <= dataLinesIn;
	end
	// A released bus shows the inverse of its last level so a stale value never passes.
	assign dataLinesIn = dataLinesOe ? dataLinesOut : !rd ? ~prevBus :
		(busy || win >= 0) ? {~last[7], tog, last[5:0]} : mem[idx(addressLines)];
endmodule

// [dv/pee_host_sva.sv]
`timescale 1ns/10ps
// ----
// Pin and user handshake protocol checks.
// ----
module pee_host_sva #(
	parameter POWER_CYC = 200
) (
	input logic        clk,
	input logic        rst_n,
	input logic        reqReady,
	input logic        rspValid,
	input logic        chipSel_n,
	input logic        outGate_n,
	input logic        writeStrobe_n,
	input logic [12:0] addressLines,
	input logic        idAreaSelectPin,
	input logic [7:0]  dataLinesOut,
	input logic        dataLinesOe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	int pwrCnt;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pwrCnt <= 0;
		else if (pwrCnt < POWER_CYC)
			pwrCnt <= pwrCnt + 1;
	end
	sequence lowHeld; !writeStrobe_n [*8]; endsequence
	sequence addrHeld; $stable(addressLines) [*8]; endsequence
	power_lock_a: assert property (reqReady |-> pwrCnt >= POWER_CYC - 1) else $error("early ready");
	read_cycle_a: assert property (!outGate_n |-> writeStrobe_n && !dataLinesOe) else $error("read clash");
	write_cycle_a: assert property (!writeStrobe_n |-> outGate_n && !chipSel_n && dataLinesOe) else $error("bad write");
	strobe_width_a: assert property ($fell(writeStrobe_n) |-> lowHeld) else $error("short strobe");
	addr_hold_a: assert property ($rose(writeStrobe_n) |-> addrHeld) else $error("address hold");
	data_stable_a: assert property (!writeStrobe_n && !$fell(writeStrobe_n) |-> $stable(dataLinesOut)) else $error("data moved");
	resp_pulse_a: assert property (rspValid |=> !rspValid) else $error("long response");
	id_window_a: assert property (idAreaSelectPin && !outGate_n |-> addressLines[12:6] == 7'h7F) else $error("id addr");
endmodule
bind pee_host pee_host_sva #(.POWER_CYC(POWER_CYC)) u_pee_host_sva (.clk(clk), .rst_n(rst_n), .reqReady(reqReady),
	.rspValid(rspValid), .chipSel_n(chipSel_n), .outGate_n(outGate_n), .writeStrobe_n(writeStrobe_n),
	.addressLines(addressLines), .idAreaSelectPin(idAreaSelectPin), .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe));

// [dv/pee_host_tb_top.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin failCount++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module pee_host_tb_top;
	logic clk = 0, rst_n = 0, reqValid = 0, reqWrite = 0, reqLast = 0, reqId = 0, gotTo;
	logic [12:0] reqAddr = 0;
	logic [7:0] reqData = 0, got;
	wire reqReady, rspValid, rspTimeout, chipSel_n, outGate_n, writeStrobe_n, idAreaSelectPin, dataLinesOe;
	wire [7:0] rspData, dataLinesIn, dataLinesOut;
	wire [12:0] addressLines;
	int failCount = 0, cmpCount = 0, progCyc = 100, n;
	always #5 clk = ~clk;
	pee_host #(.PROG_CYC(300), .POWER_CYC(200)) u_pee_host (.clk(clk), .rst_n(rst_n), .reqValid(reqValid),
		.reqWrite(reqWrite), .reqLast(reqLast), .reqId(reqId), .reqAddr(reqAddr), .reqData(reqData),
		.reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .rspTimeout(rspTimeout), .chipSel_n(chipSel_n),
		.outGate_n(outGate_n), .writeStrobe_n(writeStrobe_n), .addressLines(addressLines),
		.idAreaSelectPin(idAreaSelectPin), .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe));
	pee_dev_model u_pee_dev_model (.clk(clk), .progCyc(progCyc), .chipSel_n(chipSel_n), .outGate_n(outGate_n),
		.writeStrobe_n(writeStrobe_n), .addressLines(addressLines), .idAreaSelectPin(idAreaSelectPin),
		.dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe), .dataLinesIn(dataLinesIn));
	task automatic summarize();
		if (failCount == 0 && cmpCount > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Burst bytes keep valid high so the next byte follows with no idle gap.
	task automatic xfer(input logic w, l, id, input logic [12:0] a, input logic [7:0] d);
		reqValid <= 1; reqWrite <= w; reqLast <= l; reqId <= id; reqAddr <= a; reqData <= d;
		n = 0;
		do @(posedge clk); while (reqReady !== 1'b1 && ++n < 9000);
		`CHK(n < 9000, 1'b1)
		if (n >= 9000) summarize();
		if (w && !l) return;
		reqValid <= 0;
		n = 0;
		do @(posedge clk); while (rspValid !== 1'b1 && rspTimeout !== 1'b1 && ++n < 9000);
		`CHK(n < 9000, 1'b1)
		if (n >= 9000) summarize();
		got = rspData;
		gotTo = rspTimeout;
	endtask
	task automatic pageLoad();
		logic [12:0] ad [5] = '{13'h0105, 13'h0102, 13'h013F, 13'h0103, 13'h1555};
		logic [7:0] ex [5] = '{8'h33, 8'h22, 8'h44, 8'hFF, 8'hFF};
		xfer(1, 0, 0, 13'h0105, 8'h11);
		xfer(1, 0, 0, 13'h0102, 8'h22);
		xfer(1, 0, 0, 13'h0105, 8'h33);
		xfer(1, 1, 0, 13'h013F, 8'h44);
		`CHK(gotTo, 1'b0)
		foreach (ad[k]) begin
			xfer(0, 0, 0, ad[k], 0);
			`CHK(got, ex[k])
		end
	endtask
	task automatic fullPage();
		for (int k = 0; k < 64; k++) xfer(1, k == 63, 0, 13'(13'h0A00 + k), 8'(8'hC3 ^ k));
		`CHK(gotTo, 1'b0)
		for (int k = 0; k < 64; k += 21) begin
			xfer(0, 0, 0, 13'(13'h0A00 + k), 0);
			`CHK(got, 8'(8'hC3 ^ k))
		end
	endtask
	task automatic idArea();
		xfer(1, 1, 1, 13'h0003, 8'h5C);
		xfer(0, 0, 1, 13'h0003, 0);
		`CHK(got, 8'h5C)
		xfer(0, 0, 0, 13'h0003, 0);
		`CHK(got, 8'hFF)
	endtask
	task automatic stalledBurst();
		xfer(1, 0, 0, 13'h0300, 8'h5A);
		reqValid <= 0;
		n = 0;
		do @(posedge clk); while (rspValid !== 1'b1 && ++n < 9000);
		`CHK(n < 9000, 1'b1)
		`CHK(rspData, 8'h5A)
		xfer(0, 0, 0, 13'h0300, 0);
		`CHK(got, 8'h5A)
	endtask
	task automatic slowProgram();
		logic t6;
		progCyc = 600;
		xfer(1, 1, 0, 13'h0200, 8'h6E);
		`CHK(gotTo, 1'b1)
		xfer(0, 0, 0, 13'h0200, 0);
		`CHK(got[7], 1'b1)
		t6 = got[6];
		xfer(0, 0, 0, 13'h0200, 0);
		`CHK(got[6], ~t6)
		for (int k = 0; k < 60 && got !== 8'h6E; k++) xfer(0, 0, 0, 13'h0200, 0);
		`CHK(got, 8'h6E)
		progCyc = 100;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		`CHK(reqReady, 1'b0)
		pageLoad();
		fullPage();
		idArea();
		stalledBurst();
		slowProgram();
		summarize();
	end
endmodule

// [src/pee_consts.vh]
// How it works
// - Host writes with chip select low, output gate high, one write strobe pulse.
// - Host writes every byte the user sends; the user keeps each page burst to one to 64 bytes.
// - Host loads each next byte well within 100 us of the previous one.
// - Host passes page select bits from each request; the user keeps them fixed within one burst.
// - Host sends the three unlock writes before every write burst.
// - Host drives the id area select pin during id area accesses.
`ifndef PEE_CONSTS_VH
`define PEE_CONSTS_VH
`define PEE_CLK_NS 10
`define PEE_PROG_TIME_NS 10000000
`define PEE_PROG_CYC ((`PEE_PROG_TIME_NS) / (`PEE_CLK_NS))
`define PEE_LOAD_WIN_NS 100000
`define PEE_LOAD_WIN_CYC ((`PEE_LOAD_WIN_NS) / (`PEE_CLK_NS))
`define PEE_LOAD_GUARD_CYC ((`PEE_LOAD_WIN_CYC) / 2)
`define PEE_STROBE_NS 200
`define PEE_STROBE_CYC (((`PEE_STROBE_NS) + (`PEE_CLK_NS) - 1) / (`PEE_CLK_NS))
`define PEE_ACC_NS 200
`define PEE_ACC_CYC (((`PEE_ACC_NS) + (`PEE_CLK_NS) - 1) / (`PEE_CLK_NS))
`define PEE_HOLD_NS 100
`define PEE_HOLD_CYC (((`PEE_HOLD_NS) + (`PEE_CLK_NS) - 1) / (`PEE_CLK_NS))
`define PEE_BIT_POLL 7
`define PEE_BIT_TOGGLE 6
`define PEE_ID_BASE 13'h1FC0
`endif

// [src/pee_host.v]
`timescale 1ns/10ps
`include "pee_consts.vh"
module pee_host #(
	parameter PROG_CYC   = `PEE_PROG_CYC,
	parameter POWER_CYC  = `PEE_PROG_CYC,
	parameter [12:0] UNLOCK_A0 = 13'h1555,
	parameter [12:0] UNLOCK_A1 = 13'h0AAA,
	parameter [12:0] UNLOCK_A2 = 13'h1555,
	parameter [7:0]  UNLOCK_D0 = 8'hAA,
	parameter [7:0]  UNLOCK_D1 = 8'h55,
	parameter [7:0]  UNLOCK_D2 = 8'hA0
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        reqValid,
	input  wire        reqWrite,
	input  wire        reqLast,
	input  wire        reqId,
	input  wire [12:0] reqAddr,
	input  wire [7:0]  reqData,
	output wire        reqReady,
	output reg         rspValid,
	output reg  [7:0]  rspData,
	output reg         rspTimeout,
	output reg         chipSel_n,
	output reg         outGate_n,
	output reg         writeStrobe_n,
	output reg  [12:0] addressLines,
	output reg         idAreaSelectPin,
	input  wire [7:0]  dataLinesIn,
	output reg  [7:0]  dataLinesOut,
	output reg         dataLinesOe
);
	// ----------------------------------------
	// States.
	// ----------------------------------------
	localparam [3:0] ST_POWER = 4'h0, ST_IDLE = 4'h1, ST_RD = 4'h2, ST_WSET = 4'h3, ST_WLOW = 4'h4,
		ST_WHOLD = 4'h5, ST_WNEXT = 4'h6, ST_POLL = 4'h7, ST_PGAP = 4'h8;
	localparam TW = 20;
	localparam ACC_CYC    = `PEE_ACC_CYC;
	localparam STROBE_CYC = `PEE_STROBE_CYC;
	localparam HOLD_CYC   = `PEE_HOLD_CYC;
	// Half the byte window leaves room for the next strobe to land inside it.
	localparam GUARD_CYC  = `PEE_LOAD_GUARD_CYC;
	reg  [3:0]    state;
	reg  [1:0]    unlockIdx;
	reg           inUnlock;
	reg           isLast;
	reg  [7:0]    lastData;
	reg  [7:0]    prevPoll;
	reg           havePrev;
	reg  [12:0]   userAddr;
	reg           tLoad;
	reg  [TW-1:0] tValue;
	wire          tDone;
	wire [12:0]   uAddr = (unlockIdx == 2'd0) ? UNLOCK_A0 : (unlockIdx == 2'd1) ? UNLOCK_A1 : UNLOCK_A2;
	wire [7:0]    uData = (unlockIdx == 2'd0) ? UNLOCK_D0 : (unlockIdx == 2'd1) ? UNLOCK_D1 : UNLOCK_D2;
	// A new burst may begin only from idle; a running burst takes bytes in WNEXT.
	assign reqReady = (state == ST_IDLE) || (state == ST_WNEXT && !inUnlock);
	pee_timer #(.W(TW)) u_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.load  (tLoad),
		.value (tValue),
		.done  (tDone)
	);
	// ----------------------------------------
	// Sequencer.
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_POWER;
			unlockIdx <= 2'd0;
			inUnlock <= 1'b0;
			isLast <= 1'b0;
			lastData <= 8'h00;
			prevPoll <= 8'h00;
			havePrev <= 1'b0;
			userAddr <= 13'h0000;
			tLoad <= 1'b1;
			tValue <= POWER_CYC[TW-1:0];
			rspValid <= 1'b0;
			rspData <= 8'h00;
			rspTimeout <= 1'b0;
			chipSel_n <= 1'b1;
			outGate_n <= 1'b1;
			writeStrobe_n <= 1'b1;
			addressLines <= 13'h0000;
			idAreaSelectPin <= 1'b0;
			dataLinesOut <= 8'h00;
			dataLinesOe <= 1'b0;
		end else begin
			tLoad <= 1'b0;
			rspValid <= 1'b0;
			rspTimeout <= 1'b0;
			case (state)
				ST_POWER: begin
					if (tDone && !tLoad)
						state <= ST_IDLE;
				end
				ST_IDLE: begin
					if (reqValid) begin
						idAreaSelectPin <= reqId;
						if (reqWrite) begin
							inUnlock <= 1'b1;
							unlockIdx <= 2'd0;
							addressLines <= UNLOCK_A0;
							dataLinesOut <= UNLOCK_D0;
							lastData <= reqData;
							isLast <= reqLast;
							// The user may move on once taken, so the first address is kept here.
							userAddr <= reqId ? (`PEE_ID_BASE | reqAddr) : reqAddr;
							outGate_n <= 1'b1;
							chipSel_n <= 1'b0;
							dataLinesOe <= 1'b1;
							state <= ST_WSET;
						end else begin
							addressLines <= reqId ? (`PEE_ID_BASE | reqAddr) : reqAddr;
							dataLinesOe <= 1'b0;
							chipSel_n <= 1'b0;
							outGate_n <= 1'b0;
							tLoad <= 1'b1;
							tValue <= ACC_CYC[TW-1:0];
							state <= ST_RD;
						end
					end
				end
				ST_RD: begin
					if (tDone && !tLoad) begin
						rspValid <= 1'b1;
						rspData <= dataLinesIn;
						chipSel_n <= 1'b1;
						outGate_n <= 1'b1;
						state <= ST_IDLE;
					end
				end
				ST_WSET: begin
					writeStrobe_n <= 1'b0;
					tLoad <= 1'b1;
					tValue <= STROBE_CYC[TW-1:0];
					state <= ST_WLOW;
				end
				ST_WLOW: begin
					if (tDone && !tLoad) begin
						writeStrobe_n <= 1'b1;
						tLoad <= 1'b1;
						tValue <= HOLD_CYC[TW-1:0];
						state <= ST_WHOLD;
					end
				end
				ST_WHOLD: begin
					if (tDone && !tLoad) begin
						if (inUnlock && unlockIdx != 2'd2) begin
							unlockIdx <= unlockIdx + 2'd1;
							state <= ST_WNEXT;
						end else if (inUnlock) begin
							inUnlock <= 1'b0;
							addressLines <= userAddr;
							dataLinesOut <= lastData;
							state <= ST_WSET;
						end else if (isLast) begin
							dataLinesOe <= 1'b0;
							havePrev <= 1'b0;
							tLoad <= 1'b1;
							tValue <= PROG_CYC[TW-1:0];
							state <= ST_PGAP;
						end else begin
							tLoad <= 1'b1;
							tValue <= GUARD_CYC[TW-1:0];
							state <= ST_WNEXT;
						end
					end
				end
				ST_WNEXT: begin
					if (inUnlock) begin
						addressLines <= uAddr;
						dataLinesOut <= uData;
						state <= ST_WSET;
					end else if (reqValid && reqWrite) begin
						// Page bits follow the user; the user must keep them fixed.
						addressLines <= reqId ? (`PEE_ID_BASE | reqAddr) : reqAddr;
						dataLinesOut <= reqData;
						lastData <= reqData;
						isLast <= reqLast;
						state <= ST_WSET;
					end else if (tDone && !tLoad) begin
						// A stalled user must not let the device close the page unseen.
						dataLinesOe <= 1'b0;
						havePrev <= 1'b0;
						tLoad <= 1'b1;
						tValue <= PROG_CYC[TW-1:0];
						state <= ST_PGAP;
					end
				end
				ST_PGAP: begin
					// Reads into the array during programming are polls of the last byte.
					chipSel_n <= 1'b0;
					outGate_n <= 1'b0;
					state <= ST_POLL;
				end
				ST_POLL: begin
					if (!outGate_n && tDone && !tLoad) begin
						// Poll window expired without a stable answer.
						rspTimeout <= 1'b1;
						chipSel_n <= 1'b1;
						outGate_n <= 1'b1;
						state <= ST_IDLE;
					end else if (!outGate_n) begin
						prevPoll <= dataLinesIn;
						havePrev <= 1'b1;
						chipSel_n <= 1'b1;
						outGate_n <= 1'b1;
						if (havePrev && dataLinesIn[`PEE_BIT_POLL] == lastData[`PEE_BIT_POLL]
							&& dataLinesIn[`PEE_BIT_TOGGLE] == prevPoll[`PEE_BIT_TOGGLE]) begin
							rspValid <= 1'b1;
							rspData <= dataLinesIn;
							state <= ST_IDLE;
						end
					end else
						state <= ST_PGAP;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule

// [src/pee_timer.v]
`timescale 1ns/10ps
// ----------------------------------------
// Down counter used for the power-up wait and the access, strobe, hold, guard and poll phases.
// ----------------------------------------
module pee_timer #(
	parameter W = 20
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire         load,
	input  wire [W-1:0] value,
	output reg          done
);
	reg [W-1:0] count;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= {W{1'b0}};
			done <= 1'b1;
		end else if (load) begin
			count <= value;
			done <= (value == {W{1'b0}});
		end else if (count != {W{1'b0}}) begin
			count <= count - {{(W-1){1'b0}}, 1'b1};
			done <= (count == {{(W-1){1'b0}}, 1'b1});
		end
	end
endmodule
